// *** design/removed_pin_port_strapping.sv ***
`timescale 1ns/1ps
`include "port_strap_defines.svh"

module removed_pin_port_strapping #(
	parameter int CONV_CYCLES = 16
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	input wire port_strap_pkg::portByte_t port0PinIn,
	input wire logic [9:0] analogSampleIn,
	input wire port_strap_pkg::portByte_t port1PinIn,
	input wire port_strap_pkg::portByte_t port2PinIn,
	input wire port_strap_pkg::portByte_t port5PinIn,
	input wire port_strap_pkg::portByte_t port6PinIn,
	output port_strap_pkg::portByte_t port1Out,
	output port_strap_pkg::portByte_t port1OutEn,
	output port_strap_pkg::portByte_t port2Out,
	output port_strap_pkg::portByte_t port2OutEn,
	output port_strap_pkg::portByte_t port5Out,
	output port_strap_pkg::portByte_t port5OutEn,
	output port_strap_pkg::portByte_t port6Out,
	output port_strap_pkg::portByte_t port6OutEn
);
	import port_strap_pkg::*;

	localparam int NPORT = 4;
	localparam portByte_t FIXED_MASK [NPORT] = '{`PORT1_FIXED_MASK, `PORT2_FIXED_MASK,
		`PORT5_FIXED_MASK, `PORT6_FIXED_MASK};
	localparam portByte_t FUNC_FIXED [NPORT] = '{`PORT1_FUNC_FIXED_VALUE, `PORT2_FUNC_FIXED_VALUE,
		`PORT5_FUNC_FIXED_VALUE, `PORT6_FUNC_FIXED_VALUE};
	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

	// Per-port storage: output data, direction (1 = input), function select (1 = open-drain)
	portByte_t dataQ [NPORT];
	portByte_t dirQ [NPORT];
	portByte_t funcQ [NPORT];
	portByte_t pinIn [NPORT];
	portByte_t pinRead [NPORT];
	portByte_t dataRead [NPORT];
	portByte_t dirRead [NPORT];
	portByte_t funcRead [NPORT];
	portByte_t portOutD [NPORT];
	portByte_t portOenD [NPORT];
	portByte_t portOutQ [NPORT];
	portByte_t portOenQ [NPORT];

	assign pinIn[0] = port1PinIn;
	assign pinIn[1] = port2PinIn;
	assign pinIn[2] = port5PinIn;
	assign pinIn[3] = port6PinIn;

	wire logic accessReq = (avsRead | avsWrite) & clkEn;
	wire logic [5:0] wordIdx = avsAddress[7:2];
	// Waitrequest drops for one cycle, the cycle after a request is seen
	logic waitQ;
	wire logic ack = ~waitQ;
	// Write lands at the edge where waitrequest is sampled low
	wire logic writeTake = avsWrite & clkEn & ack;
	wire logic loadLane = avsByteEnable[0];

	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : gPort
			wire logic wrData = writeTake & loadLane & (wordIdx == 6'(4 * p + 1));
			wire logic wrDir = writeTake & loadLane & (wordIdx == 6'(4 * p + 2));
			wire logic wrFunc = writeTake & loadLane & (wordIdx == 6'(4 * p + 3));
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					dataQ[p] <= `OUTPUT_DATA_RESET;
					dirQ[p] <= `DIRECTION_RESET;
					funcQ[p] <= `FUNCTION_SELECT_RESET;
					portOutQ[p] <= 8'h00;
					portOenQ[p] <= 8'h00;
				end else if (clkEn) begin
					if (wrData)
						dataQ[p] <= avsWriteData[7:0];
					if (wrDir)
						dirQ[p] <= avsWriteData[7:0];
					if (wrFunc)
						funcQ[p] <= avsWriteData[7:0];
					portOutQ[p] <= portOutD[p];
					portOenQ[p] <= portOenD[p];
				end
			end
			// Fixed bits override storage, so writes there have no visible effect
			assign pinRead[p] = (pinIn[p] & ~FIXED_MASK[p]) | (`PIN_FIXED_VALUE & FIXED_MASK[p]);
			assign dataRead[p] = (dataQ[p] & ~FIXED_MASK[p]) | (`PIN_FIXED_VALUE & FIXED_MASK[p]);
			assign dirRead[p] = (dirQ[p] & ~FIXED_MASK[p]) | (`PIN_FIXED_VALUE & FIXED_MASK[p]);
			assign funcRead[p] = (funcQ[p] & ~FIXED_MASK[p]) | (FUNC_FIXED[p] & FIXED_MASK[p]);
			// Open-drain drives only low, except the port 2 clock output bit; removed pins never drive
			assign portOenD[p] = ~dirRead[p] & ~FIXED_MASK[p]
				& ~(funcRead[p] & dataRead[p] & ~((p == 1) ? 8'(1 << `CLOCK_OUTPUT_BIT) : 8'h00));
			assign portOutD[p] = dataRead[p];
		end
	endgenerate

	assign port1Out = portOutQ[0];
	assign port1OutEn = portOenQ[0];
	assign port2Out = portOutQ[1];
	assign port2OutEn = portOenQ[1];
	assign port5Out = portOutQ[2];
	assign port5OutEn = portOenQ[2];
	assign port6Out = portOutQ[3];
	assign port6OutEn = portOenQ[3];

	wire portByte_t port0Read = port0PinIn & ~`PORT0_FIXED_MASK;

	// Analog converter front end
	analogState_t anaStateQ;
	analogState_t anaStateD;
	analogChannel_t anaChanQ;
	logic [7:0] anaCountQ;
	logic [9:0] anaResultQ;
	logic anaDoneQ;
	wire logic wrAnaCtl = writeTake & (wordIdx == 6'(`ANALOG_CONTROL_ADDR >> 2)) & avsByteEnable[1];
	wire logic anaStart = wrAnaCtl & avsWriteData[`ANALOG_START_BIT] & (anaStateQ == ANALOG_IDLE);
	wire logic anaFinish = (anaStateQ == ANALOG_CONVERT) & (anaCountQ == CONV_LAST);
	wire logic anaTiedRef = (anaChanQ == 3'h0) | (anaChanQ == 3'h1);
	wire logic [9:0] anaSample = anaTiedRef ? `ANALOG_FULL_SCALE : analogSampleIn;

	always_comb begin
		case (anaStateQ)
			ANALOG_IDLE: anaStateD = anaStart ? ANALOG_CONVERT : ANALOG_IDLE;
			ANALOG_CONVERT: anaStateD = anaFinish ? ANALOG_IDLE : ANALOG_CONVERT;
			default: anaStateD = ANALOG_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			anaStateQ <= ANALOG_IDLE;
			anaChanQ <= 3'h0;
			anaCountQ <= 8'h00;
			anaResultQ <= 10'h000;
			anaDoneQ <= 1'b0;
		end else if (clkEn) begin
			anaStateQ <= anaStateD;
			anaCountQ <= (anaStateQ == ANALOG_CONVERT) ? anaCountQ + 8'h01 : 8'h00;
			if (anaStart) begin
				anaChanQ <= avsWriteData[2:0];
				anaDoneQ <= 1'b0;
			end else if (anaFinish) begin
				anaResultQ <= anaSample;
				anaDoneQ <= 1'b1;
			end
		end
	end

	// Read multiplexer
	logic [31:0] readMux;
	always_comb begin
		readMux = 32'h0000_0000;
		if (wordIdx < 6'h10) begin
			case (wordIdx[1:0])
				2'h0: readMux = {24'h000000, pinRead[wordIdx[3:2]]};
				2'h1: readMux = {24'h000000, dataRead[wordIdx[3:2]]};
				2'h2: readMux = {24'h000000, dirRead[wordIdx[3:2]]};
				default: readMux = {24'h000000, funcRead[wordIdx[3:2]]};
			endcase
		end else if (wordIdx == 6'(`PORT0_PIN_INPUT_ADDR >> 2))
			readMux = {24'h000000, port0Read};
		else if (wordIdx == 6'(`ANALOG_CONTROL_ADDR >> 2))
			readMux = {14'h0000, anaDoneQ, anaStateQ == ANALOG_CONVERT, 13'h0000, anaChanQ};
		else if (wordIdx == 6'(`ANALOG_RESULT_ADDR >> 2))
			readMux = {22'h000000, anaResultQ};
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			waitQ <= 1'b1;
			avsReadData <= 32'h0000_0000;
		end else if (clkEn) begin
			waitQ <= ~(accessReq & waitQ);
			if (avsRead & waitQ)
				avsReadData <= readMux;
		end
	end

	assign avsWaitRequest = waitQ;
endmodule : removed_pin_port_strapping

// *** design/port_strap_defines.svh ***
`ifndef PORT_STRAP_DEFINES_SVH
`define PORT_STRAP_DEFINES_SVH
// Register byte addresses (one 32-bit word each)
`define PORT1_PIN_INPUT_ADDR 8'h00
`define PORT1_OUTPUT_DATA_ADDR 8'h04
`define PORT1_DIRECTION_ADDR 8'h08
`define PORT1_FUNCTION_SELECT_ADDR 8'h0C
`define PORT2_PIN_INPUT_ADDR 8'h10
`define PORT2_OUTPUT_DATA_ADDR 8'h14
`define PORT2_DIRECTION_ADDR 8'h18
`define PORT2_FUNCTION_SELECT_ADDR 8'h1C
`define PORT5_PIN_INPUT_ADDR 8'h20
`define PORT5_OUTPUT_DATA_ADDR 8'h24
`define PORT5_DIRECTION_ADDR 8'h28
`define PORT5_FUNCTION_SELECT_ADDR 8'h2C
`define PORT6_PIN_INPUT_ADDR 8'h30
`define PORT6_OUTPUT_DATA_ADDR 8'h34
`define PORT6_DIRECTION_ADDR 8'h38
`define PORT6_FUNCTION_SELECT_ADDR 8'h3C
`define PORT0_PIN_INPUT_ADDR 8'h40
`define ANALOG_CONTROL_ADDR 8'h44
`define ANALOG_RESULT_ADDR 8'h48
// Hard-wired bit masks per port
`define PORT1_FIXED_MASK 8'hF0
`define PORT2_FIXED_MASK 8'h28
`define PORT5_FIXED_MASK 8'h82
`define PORT6_FIXED_MASK 8'h0C
`define PORT0_FIXED_MASK 8'h03
// Values read from hard-wired bits
`define PIN_FIXED_VALUE 8'hFF
`define PORT1_FUNC_FIXED_VALUE 8'h00
`define PORT2_FUNC_FIXED_VALUE 8'h00
`define PORT5_FUNC_FIXED_VALUE 8'h80
`define PORT6_FUNC_FIXED_VALUE 8'h00
`define PORT0_FIXED_VALUE 8'h00
// Clock output bit within port 2
`define CLOCK_OUTPUT_BIT 7
// Reset values
`define OUTPUT_DATA_RESET 8'hFF
`define DIRECTION_RESET 8'hFF
`define FUNCTION_SELECT_RESET 8'h00
// Analog converter
`define ANALOG_FULL_SCALE 10'h3FF
`define ANALOG_CHAN_SEL_LSB 0
`define ANALOG_START_BIT 8
`define ANALOG_BUSY_BIT 16
`define ANALOG_DONE_BIT 17
`define ANALOG_CONV_CYCLES 8'h10
`endif

// *** design/port_strap_pkg.sv ***
package port_strap_pkg;
	typedef logic [7:0] portByte_t;
	typedef logic [2:0] analogChannel_t;
	typedef enum logic [1:0] {
		ANALOG_IDLE,
		ANALOG_CONVERT
	} analogState_t;
endpackage : port_strap_pkg

// *** testbench/port_strap_asserts.sv ***
`timescale 1ns/1ps
module port_strap_asserts (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire port_strap_pkg::portByte_t port1OutEn,
	input wire port_strap_pkg::portByte_t port2OutEn,
	input wire port_strap_pkg::portByte_t port5OutEn,
	input wire port_strap_pkg::portByte_t port6OutEn
);
	wire logic ack = avsRead && !avsWaitRequest;
	wire logic fs = avsAddress[3:2] == 2'h3;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_ack_next: assert property ((avsRead || avsWrite) && avsWaitRequest && clkEn |=> !avsWaitRequest)
		else $error("no answer one cycle after request");
	chk_ack_single: assert property (!avsWaitRequest && clkEn |=> avsWaitRequest)
		else $error("answer longer than one cycle");
	chk_port1_fixed: assert property (ack && avsAddress[7:4] == 4'h0 |-> avsReadData[7:4] == (fs ? 4'h0 : 4'hF))
		else $error("port 1 fixed bits wrong");
	chk_port2_fixed: assert property (ack && avsAddress[7:4] == 4'h1 |-> {avsReadData[5], avsReadData[3]} == (fs ? 2'h0 : 2'h3))
		else $error("port 2 fixed bits wrong");
	chk_port5_fixed: assert property (ack && avsAddress[7:4] == 4'h2 |-> {avsReadData[7], avsReadData[1]} == (fs ? 2'h2 : 2'h3))
		else $error("port 5 fixed bits wrong");
	chk_port6_fixed: assert property (ack && avsAddress[7:4] == 4'h3 |-> avsReadData[3:2] == (fs ? 2'h0 : 2'h3))
		else $error("port 6 fixed bits wrong");
	chk_port0_low: assert property (ack && avsAddress[7:2] == 6'h10 |-> avsReadData[1:0] == 2'h0)
		else $error("port 0 low bits not zero");
	chk_fixed_undriven: assert property (port1OutEn[7:4] == 4'h0 && port6OutEn[3:2] == 2'h0 && !port2OutEn[5] && !port2OutEn[3] && !port5OutEn[7] && !port5OutEn[1])
		else $error("removed pin driven");
	cover property (ack && avsAddress[7:2] == 6'h10);
	cover property (avsWrite && !avsWaitRequest);
	cover property (port2OutEn[7]);
endmodule : port_strap_asserts
bind removed_pin_port_strapping port_strap_asserts port_strap_asserts_i (.*);

// *** testbench/removed_pin_port_strapping_test.sv ***
`timescale 1ns/1ps
module removed_pin_port_strapping_test;
	import port_strap_pkg::*;
	logic mclk, rstn, clkEn, avsRead, avsWrite, avsWaitRequest;
	logic [7:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData, pv, rv, s, v;
	logic [3:0] avsByteEnable;
	logic [9:0] analogSampleIn;
	portByte_t port0PinIn, port1Out, port1OutEn, port2Out, port2OutEn, port5Out, port5OutEn, port6Out, port6OutEn;
	portByte_t oe[4], ov[4];
	wire portByte_t port1PinIn = pv[7:0];
	wire portByte_t port2PinIn = pv[15:8];
	wire portByte_t port5PinIn = pv[23:16];
	wire portByte_t port6PinIn = pv[31:24];
	int n_errors = 0, num_checks = 0, e, k;
	int dat[4], dir[4], fn[4];
	int msk[4] = '{8'hF0, 8'h28, 8'h82, 8'h0C};
	int fnf[4] = '{8'h00, 8'h00, 8'h80, 8'h00};
	assign oe = '{port1OutEn, port2OutEn, port5OutEn, port6OutEn};
	assign ov = '{port1Out, port2Out, port5Out, port6Out};
	removed_pin_port_strapping #(.CONV_CYCLES(4)) removed_pin_port_strapping_i (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= w;
		avsRead <= !w;
		do begin
			@(posedge mclk);
		end while (avsWaitRequest !== 1'b0);
		rv = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge mclk);
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rv, exp);
	endtask : rd
	task automatic chkall;
		int x;
		for (int p = 0; p < 4; p++) begin
			rd(8'(p * 16), 32'((pv >> (8 * p)) & 32'hFF | msk[p]));
			rd(8'(p * 16 + 4), dat[p]);
			rd(8'(p * 16 + 8), dir[p]);
			rd(8'(p * 16 + 12), fn[p]);
			x = ~dir[p] & ~msk[p] & ~(fn[p] & dat[p]) & 255;
			if (p == 1) x = (x & 8'h7F) | (~dir[p] & 8'h80);
			chk("enable", 32'(oe[p]), x);
			chk("drive", 32'(ov[p]), dat[p]);
		end
		rd(8'h40, 32'(port0PinIn & 8'hFC));
	endtask : chkall
	task automatic test_done;
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		test_done;
	end
	initial begin
		{rstn, avsRead, avsWrite, avsAddress, avsWriteData, pv, rv, port0PinIn} = '0;
		clkEn = 1'b1;
		avsByteEnable = 4'hF;
		analogSampleIn = 10'h2A5;
		s = 32'h9;
		for (int p = 0; p < 4; p++) begin
			dat[p] = 255;
			dir[p] = 255;
			fn[p] = fnf[p];
		end
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chkall;
		for (int i = 0; i < 6; i++) begin
			for (int p = 0; p < 4; p++) begin
				for (int r = 1; r < 4; r++) begin
					s = lfsr(s);
					v = (i == 5) ? ((r == 2) ? 32'h0 : 32'h80) : s;
					acc(1'b1, 8'(p * 16 + r * 4), v);
					e = (v & ~msk[p] & 255) | ((r == 3 ? fnf[p] : 255) & msk[p]);
					if (r == 1) dat[p] = e;
					else if (r == 2) dir[p] = e;
					else fn[p] = e;
				end
			end
			s = lfsr(s);
			pv <= s;
			port0PinIn <= s[15:8] ^ 8'hA7;
			analogSampleIn <= s[25:16];
			repeat (4) @(posedge mclk);
			chkall;
		end
		for (int ch = 0; ch < 4; ch++) begin
			acc(1'b1, 8'h44, 32'h100 | ch);
			k = 0;
			do begin
				acc(1'b0, 8'h44, 32'h0);
				k++;
			end while (!(rv[16] === 1'b0 && rv[17] === 1'b1) && k < 20);
			chk("status", 32'(rv[17:16]), 32'h2);
			acc(1'b0, 8'h48, 32'h0);
			chk("result", rv[9:0], ch < 2 ? 10'h3FF : analogSampleIn);
		end
		acc(1'b1, 8'h4C, s);
		rd(8'h4C, 32'h0);
		test_done;
	end
endmodule : removed_pin_port_strapping_test
